//--- hw/pll_divider_phase_selector.sv
// divider, phase selector and lock indicator of a multiphase clock generator
// assumes CLK_I is the oscillator-rate tick; all device pins are asynchronous to it
//
// Function
// - lock high when reference and feedback edges coincide
// - test bypass clocks divider from reference input
// - bypass enters after first halving stage
// - divider select low divides four, high eight
// - aux enable low gates double and half
// - main enable low gates four phase outputs
// - dup enable gates duplicate bank independently
// - duplicate outputs copy main outputs while both bank enables match
// - double rate equals a, or twice
// - half rate at half a, rising aligned
// - active-low reset pin clears divider state
// - code 00: all main outputs aligned
// - code 01: quarter period lags b,c,d
// - later feedback shifts all outputs equally
// - code 11: lags of one, two, three steps
// - code 10: b leads, c lags, d quarter
// - half rate feedback doubles main frequency
// - disabled bank holds its outputs high
// - phase step equals one oscillator period
// - state clears one cycle before outputs low
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps

module pll_divider_phase_selector
	import pll_div_pkg::*;
(
	// clock, reset, clock enable
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic        CE_I,
	// ahb-lite slave
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	// device pins
	input  wire logic        REFERENCE_IN_I,
	input  wire logic        FEEDBACK_IN_I,
	input  wire logic        DIVIDER_SELECT_I,
	input  wire logic        PHASE_SELECT_LSB_I,
	input  wire logic        PHASE_SELECT_MSB_I,
	input  wire logic        AUX_BANK_ENABLE_N_I,
	input  wire logic        MAIN_BANK_ENABLE_N_I,
	input  wire logic        DUP_BANK_ENABLE_N_I,
	input  wire logic        TEST_BYPASS_I,
	input  wire logic        RESET_N_I,
	// clock outputs and lock
	output logic      [3:0]  PHASE_OUT_O,
	output logic      [3:0]  DUP_OUT_O,
	output logic             HALF_RATE_OUT_O,
	output logic             DOUBLE_RATE_OUT_O,
	output logic             LOCK_O
);

	// ==========================================================
	// tap offset in oscillator steps; negative values wrap mod 16
	function automatic logic [3:0] tap_offset(input logic [1:0] sel, input logic div8,
	                                          input int idx);
		logic [3:0] quarter;
		logic [3:0] off;
		quarter = div8 ? 4'h2 : 4'h1;
		off     = 4'h0;
		unique case (sel)
			PH_ALIGNED: off = 4'h0;
			PH_QUARTER: off = 4'(quarter * 4'(idx));
			PH_EARLY: begin
				if (idx == 1) off = 4'hF;
				else if (idx == 2) off = 4'h1;
				else if (idx == 3) off = quarter;
				else off = 4'h0;
			end
			PH_STEP: off = 4'(idx);
		endcase
		return off;
	endfunction

	// clock level of a tap: high in the first half of the divided period
	function automatic logic tap_level(input logic [3:0] cnt, input logic [3:0] off,
	                                   input logic div8);
		logic [3:0] d;
		d = cnt - off;
		return div8 ? ~d[2] : ~d[1];
	endfunction

	// ==========================================================
	// pin synchronisers: three stages, accept once stages two and three agree
	logic [NUM_PINS-1:0] pin_raw;
	logic [NUM_PINS-1:0] s1_r;
	logic [NUM_PINS-1:0] s2_r;
	logic [NUM_PINS-1:0] s3_r;
	logic [NUM_PINS-1:0] pin_r;
	logic [NUM_PINS-1:0] pin_nxt;
	logic [NUM_PINS-1:0] pin_prev_r;

	assign pin_raw = {RESET_N_I, TEST_BYPASS_I, DUP_BANK_ENABLE_N_I, MAIN_BANK_ENABLE_N_I,
	                  AUX_BANK_ENABLE_N_I, PHASE_SELECT_MSB_I, PHASE_SELECT_LSB_I,
	                  DIVIDER_SELECT_I, FEEDBACK_IN_I, REFERENCE_IN_I};

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_sync
			always_comb begin
				pin_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : pin_r[g];
			end
		end
	endgenerate

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			s1_r       <= PIN_IDLE;
			s2_r       <= PIN_IDLE;
			s3_r       <= PIN_IDLE;
			pin_r      <= PIN_IDLE;
			pin_prev_r <= PIN_IDLE;
		end else if (CE_I) begin
			s1_r       <= pin_raw;
			s2_r       <= s1_r;
			s3_r       <= s2_r;
			pin_r      <= pin_nxt;
			pin_prev_r <= pin_r;
		end
	end

	// edge history starts at each pin's rest level, so reset makes no false edge
	logic ref_rise;
	logic fb_rise;
	logic pin_reset;
	assign ref_rise  = pin_r[PIN_REF] & ~pin_prev_r[PIN_REF];
	assign fb_rise   = pin_r[PIN_FB] & ~pin_prev_r[PIN_FB];
	assign pin_reset = ~pin_r[PIN_RST_N];

	// ==========================================================
	// register file
	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;
	logic        wr_pend_r;
	logic        wr_pend_nxt;
	logic [7:0]  wr_addr_r;
	logic [7:0]  wr_addr_nxt;
	logic [31:0] rdata_nxt;
	logic [31:0] status;
	logic        addr_valid;
	pin_cfg_t    cfg_r;
	pin_cfg_t    cfg_nxt;
	logic [3:0]  cnt_r;
	logic        lock_r;

	assign addr_valid = HSEL_I & (HTRANS_I == HTRANS_NONSEQ) & HREADY_I;

	always_comb begin
		status                          = 32'h0000_0000;
		status[ST_LOCK_BIT]             = lock_r;
		status[ST_TEST_BIT]             = cfg_r.test_bypass;
		status[ST_DIV8_BIT]             = cfg_r.divide_by_eight;
		status[ST_PHASE_LSB +: 2]       = cfg_r.phase_select;
		status[ST_CNT_LSB +: 4]         = cnt_r;
		ctrl_nxt    = ctrl_r;
		wr_pend_nxt = addr_valid & HWRITE_I;
		wr_addr_nxt = addr_valid ? HADDR_I[7:0] : wr_addr_r;
		// read data stands until the next read address phase is taken
		rdata_nxt   = HRDATA_O;
		if (wr_pend_r && wr_addr_r == ADDR_CTRL) begin
			ctrl_nxt = HWDATA_I;
		end
		if (addr_valid && !HWRITE_I) begin
			// unmapped addresses read as zero and still answer okay
			if (HADDR_I[7:0] == ADDR_CTRL) rdata_nxt = ctrl_r;
			else if (HADDR_I[7:0] == ADDR_STATUS) rdata_nxt = status;
			else rdata_nxt = RDATA_RST;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ctrl_r      <= CTRL_RST;
			wr_pend_r   <= 1'b0;
			wr_addr_r   <= ADDR_CTRL;
			HRDATA_O    <= RDATA_RST;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end else if (CE_I) begin
			ctrl_r      <= ctrl_nxt;
			wr_pend_r   <= wr_pend_nxt;
			wr_addr_r   <= wr_addr_nxt;
			HRDATA_O    <= rdata_nxt;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end
	end

	// ==========================================================
	// divider counter and configuration
	// software hold acts like the reset pin, so the bench can restart phases
	logic       hold;
	logic       hold_d_r;
	logic [3:0] cnt_nxt;
	logic [3:0] step;

	assign hold = pin_reset | ctrl_r[CTRL_HOLD_BIT];

	always_comb begin
		cfg_nxt = cfg_r;
		if (hold) begin
			// sampled only while held in reset; later changes are ignored
			cfg_nxt.test_bypass     = pin_r[PIN_TEST];
			cfg_nxt.divide_by_eight = pin_r[PIN_DIV];
			cfg_nxt.phase_select    = {pin_r[PIN_PH_MSB], pin_r[PIN_PH_LSB]};
		end
		if (cfg_r.test_bypass) begin
			step = ref_rise ? STEP_BYPASS : STEP_NONE;
		end else begin
			step = STEP_OSC;
		end
		// the count is held one cycle past the hold, so the first visible
		// count after release is zero and tap a starts with a full high phase
		cnt_nxt = (hold | hold_d_r) ? CNT_RST : cnt_r + step;
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			cfg_r    <= CFG_RST;
			cnt_r    <= CNT_RST;
			hold_d_r <= 1'b1;
		end else if (CE_I) begin
			cfg_r    <= cfg_nxt;
			cnt_r    <= cnt_nxt;
			hold_d_r <= hold;
		end
	end

	// ==========================================================
	// output taps, all from the one counter
	logic [3:0] phase_nxt;
	logic [3:0] dup_nxt;
	logic       half_nxt;
	logic       double_nxt;

	generate
		for (g = 0; g < 4; g++) begin : g_tap
			logic lvl;
			always_comb begin
				// all taps ride the one counter, so any fed-back tap shifts all alike
				lvl = tap_level(cnt_r, tap_offset(cfg_r.phase_select,
				                cfg_r.divide_by_eight, g), cfg_r.divide_by_eight);
				if (hold_d_r) begin
					phase_nxt[g] = 1'b0;
					dup_nxt[g]   = 1'b0;
				end else begin
					phase_nxt[g] = pin_r[PIN_MAIN_N] ? 1'b1 : lvl;
					dup_nxt[g]   = pin_r[PIN_DUP_N] ? 1'b1 : lvl;
				end
			end
		end
	endgenerate

	always_comb begin
		logic half_lvl;
		logic dbl_lvl;
		// half rate rises where tap a rises on every second period
		half_lvl = cfg_r.divide_by_eight ? cnt_r[3] : cnt_r[2];
		// one tap serves both ratios: equal to a at four, twice a at eight
		dbl_lvl  = ~cnt_r[1];
		if (hold_d_r) begin
			half_nxt   = 1'b0;
			double_nxt = 1'b0;
		end else begin
			half_nxt   = pin_r[PIN_AUX_N] ? 1'b1 : half_lvl;
			double_nxt = pin_r[PIN_AUX_N] ? 1'b1 : dbl_lvl;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			PHASE_OUT_O       <= 4'h0;
			DUP_OUT_O         <= 4'h0;
			HALF_RATE_OUT_O   <= 1'b0;
			DOUBLE_RATE_OUT_O <= 1'b0;
		end else if (CE_I) begin
			PHASE_OUT_O       <= phase_nxt;
			DUP_OUT_O         <= dup_nxt;
			HALF_RATE_OUT_O   <= half_nxt;
			DOUBLE_RATE_OUT_O <= double_nxt;
		end
	end

	// ==========================================================
	// lock detect: each reference edge opens a window; the verdict is
	// given when the window closes. resolution is one system clock, far
	// coarser than the analog detector, so this only tells edge coincidence.
	// the analog loop aligns whichever output the board feeds back
	// so only coincidence of the two pins is judged here.
	// hold leaves the verdict alone: the loop keeps tracking through it.
	logic [2:0] ref_age_r;
	logic [2:0] ref_age_nxt;
	logic [2:0] fb_age_r;
	logic [2:0] fb_age_nxt;
	logic       match_r;
	logic       match_nxt;
	logic       lock_nxt;

	always_comb begin
		ref_age_nxt = ref_rise ? 3'h0 : (ref_age_r == AGE_MAX ? AGE_MAX : ref_age_r + 3'h1);
		fb_age_nxt  = fb_rise ? 3'h0 : (fb_age_r == AGE_MAX ? AGE_MAX : fb_age_r + 3'h1);
		match_nxt   = match_r;
		lock_nxt    = lock_r;
		if (ref_rise) begin
			match_nxt = fb_rise | (fb_age_r < LOCK_WIN);
		end else if (fb_rise && ref_age_r < LOCK_WIN) begin
			match_nxt = 1'b1;
		end
		if (ref_age_r == LOCK_WIN) begin
			lock_nxt = match_r;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ref_age_r <= AGE_MAX;
			fb_age_r  <= AGE_MAX;
			match_r   <= 1'b0;
			lock_r    <= 1'b0;
			LOCK_O    <= 1'b0;
		end else if (CE_I) begin
			ref_age_r <= ref_age_nxt;
			fb_age_r  <= fb_age_nxt;
			match_r   <= match_nxt;
			lock_r    <= lock_nxt;
			LOCK_O    <= lock_nxt;
		end
	end

endmodule

//--- hw/pll_div_pkg.sv
// constants and carrier types for the pll divider and phase selector
// assumes one 20 MHz system clock standing in for the oscillator rate
package pll_div_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS   = 50;
	localparam int LOCK_WINDOW_NS  = 4;
	// longest time rounds down, never below one cycle
	localparam int LOCK_WINDOW_CYC = (LOCK_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 :
	                                 (LOCK_WINDOW_NS / CLK_PERIOD_NS);
	localparam logic [2:0] LOCK_WIN = 3'(LOCK_WINDOW_CYC);
	localparam logic [2:0] AGE_MAX  = 3'h7;

	// ==========================================================
	// divider
	localparam logic [3:0] CNT_RST      = 4'h0;
	localparam logic [3:0] STEP_OSC     = 4'h1;
	localparam logic [3:0] STEP_BYPASS  = 4'h2;
	localparam logic [3:0] STEP_NONE    = 4'h0;

	// ==========================================================
	// pin synchroniser lanes and their idle values
	localparam int NUM_PINS   = 10;
	localparam int PIN_REF    = 0;
	localparam int PIN_FB     = 1;
	localparam int PIN_DIV    = 2;
	localparam int PIN_PH_LSB = 3;
	localparam int PIN_PH_MSB = 4;
	localparam int PIN_AUX_N  = 5;
	localparam int PIN_MAIN_N = 6;
	localparam int PIN_DUP_N  = 7;
	localparam int PIN_TEST   = 8;
	localparam int PIN_RST_N  = 9;
	localparam logic [NUM_PINS-1:0] PIN_IDLE = 10'h2E0;

	// ==========================================================
	// register map
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_STATUS    = 8'h04;
	localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
	localparam int          CTRL_HOLD_BIT  = 0;
	localparam int          ST_LOCK_BIT    = 0;
	localparam int          ST_TEST_BIT    = 1;
	localparam int          ST_DIV8_BIT    = 2;
	localparam int          ST_PHASE_LSB   = 3;
	localparam int          ST_CNT_LSB     = 8;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
	localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

	// ==========================================================
	// phase select codes
	localparam logic [1:0] PH_ALIGNED = 2'b00;
	localparam logic [1:0] PH_QUARTER = 2'b01;
	localparam logic [1:0] PH_EARLY   = 2'b10;
	localparam logic [1:0] PH_STEP    = 2'b11;

	// configuration caught while reset is held
	typedef struct packed {
		logic       test_bypass;
		logic       divide_by_eight;
		logic [1:0] phase_select;
	} pin_cfg_t;

	localparam pin_cfg_t CFG_RST = '{test_bypass: 1'b0, divide_by_eight: 1'b0,
	                                 phase_select: PH_ALIGNED};

endpackage

//--- tb/pll_div_assertions.sv
// checker: bank gating, resets and edge alignment of the divider outputs
// assumes it is bound into pll_divider_phase_selector; pins settle within 8 cycles
`timescale 1ns/1ps

module pll_div_assertions (
	// clock and resets
	input wire logic       CLK_I,
	input wire logic       RST_I,
	input wire logic       RESET_N_I,
	// bank enables
	input wire logic       AUX_BANK_ENABLE_N_I,
	input wire logic       MAIN_BANK_ENABLE_N_I,
	input wire logic       DUP_BANK_ENABLE_N_I,
	// outputs
	input wire logic [3:0] PHASE_OUT_O,
	input wire logic [3:0] DUP_OUT_O,
	input wire logic       HALF_RATE_OUT_O,
	input wire logic       DOUBLE_RATE_OUT_O,
	input wire logic       LOCK_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	// ==========================================================
	// bank gating; eight quiet cycles cover the pin synchroniser
	wire run  = RESET_N_I;
	wire both = !AUX_BANK_ENABLE_N_I && !MAIN_BANK_ENABLE_N_I && RESET_N_I;

	AST_MAIN_OFF: assert property (
		(MAIN_BANK_ENABLE_N_I && run)[*8] |-> PHASE_OUT_O == 4'hF)
		else $error("main bank not held high");
	AST_AUX_OFF: assert property (
		(AUX_BANK_ENABLE_N_I && run)[*8] |-> HALF_RATE_OUT_O && DOUBLE_RATE_OUT_O)
		else $error("aux bank not held high");
	AST_DUP_OFF: assert property (
		(DUP_BANK_ENABLE_N_I && run)[*8] |-> DUP_OUT_O == 4'hF)
		else $error("dup bank not held high");
	AST_DUP_COPY: assert property (
		(DUP_BANK_ENABLE_N_I == MAIN_BANK_ENABLE_N_I && run)[*8] |-> DUP_OUT_O == PHASE_OUT_O)
		else $error("dup bank differs from main bank");

	// ==========================================================
	// edge alignment
	AST_DBL_RISE: assert property (
		both[*8] ##0 $rose(PHASE_OUT_O[0]) |-> $rose(DOUBLE_RATE_OUT_O))
		else $error("double rate not rising with phase a");
	AST_HALF_RISE: assert property (
		both[*8] ##0 $rose(HALF_RATE_OUT_O) |-> $rose(PHASE_OUT_O[0]))
		else $error("half rate rise off phase a");

	// ==========================================================
	// resets
	AST_PIN_HOLD: assert property (
		(!RESET_N_I)[*8] |-> {PHASE_OUT_O, DUP_OUT_O} == 8'h00
		&& !HALF_RATE_OUT_O && !DOUBLE_RATE_OUT_O)
		else $error("outputs not low in pin reset");
	AST_SYS_RST: assert property (disable iff (1'b0)
		RST_I |=> PHASE_OUT_O == 4'h0 && DUP_OUT_O == 4'h0 && !LOCK_O)
		else $error("outputs not cleared by system reset");

	cover property ($rose(LOCK_O));
	cover property (both[*8] ##0 $rose(DOUBLE_RATE_OUT_O));
	cover property ((!RESET_N_I)[*8]);
endmodule

bind pll_divider_phase_selector pll_div_assertions pll_div_assertions_i (
	.CLK_I, .RST_I, .RESET_N_I, .AUX_BANK_ENABLE_N_I, .MAIN_BANK_ENABLE_N_I,
	.DUP_BANK_ENABLE_N_I, .PHASE_OUT_O, .DUP_OUT_O, .HALF_RATE_OUT_O,
	.DOUBLE_RATE_OUT_O, .LOCK_O);

//--- tb/ref_src_model.sv
// reference clock source and board feedback path
// assumes the bench clock; the reference free-runs, as a crystal would
`timescale 1ns/1ps

module ref_src_model (
	// control
	input  wire logic       clk_i,
	input  wire logic [3:0] half_i,
	input  wire logic [2:0] fb_sel_i,
	// taps: a..d, half, double
	input  wire logic [5:0] taps_i,
	// pins
	output logic            ref_o,
	output logic            fb_o
);
	logic [3:0] cnt_r = 4'h0;

	initial ref_o = 1'b0;
	always @(posedge clk_i) begin
		if (cnt_r + 4'h1 >= half_i) begin
			cnt_r <= 4'h0;
			ref_o <= !ref_o;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	// one path closes the loop: a tap, a zero-delay copy (6) or open (7)
	assign fb_o = fb_sel_i == 3'h6 ? ref_o : fb_sel_i == 3'h7 ? 1'b0 : taps_i[fb_sel_i];
endmodule

//--- tb/tb.sv
// self-checking bench for the pll divider and phase selector
// assumes the reference source model drives the reference and feedback pins
`timescale 1ns/1ps

module tb
	import pll_div_pkg::*;
;
	// ==========================================================
	// pins and bench state
	logic        CLK_I = 1'b0, RST_I = 1'b1, CE_I = 1'b1, HSEL_I = 1'b0, HWRITE_I = 1'b0;
	logic [31:0] HADDR_I = 32'h0, HWDATA_I = 32'h0, q, r;
	logic [1:0]  HTRANS_I = 2'h0;
	logic [2:0]  HSIZE_I = 3'h2, fb_sel = 3'h7;
	logic [3:0]  half_r = 4'h5;
	logic        DIVIDER_SELECT_I = 1'b0, PHASE_SELECT_LSB_I = 1'b0, PHASE_SELECT_MSB_I = 1'b0;
	logic        TEST_BYPASS_I = 1'b0, RESET_N_I = 1'b1, AUX_BANK_ENABLE_N_I = 1'b1;
	logic        MAIN_BANK_ENABLE_N_I = 1'b1, DUP_BANK_ENABLE_N_I = 1'b1;
	wire         HREADY_I, REFERENCE_IN_I, FEEDBACK_IN_I, HREADYOUT_O, HRESP_O;
	wire         HALF_RATE_OUT_O, DOUBLE_RATE_OUT_O, LOCK_O;
	wire  [3:0]  PHASE_OUT_O, DUP_OUT_O;
	wire  [31:0] HRDATA_O;
	int          err_count = 0, total_checks = 0, seed = 32'h0000_665B, d, c;

	assign HREADY_I = HREADYOUT_O;
	always #25 CLK_I = !CLK_I;

	pll_divider_phase_selector pll_divider_phase_selector_i (
		.CLK_I, .RST_I, .CE_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HSIZE_I, .HWDATA_I,
		.HREADY_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O, .REFERENCE_IN_I, .FEEDBACK_IN_I,
		.DIVIDER_SELECT_I, .PHASE_SELECT_LSB_I, .PHASE_SELECT_MSB_I, .AUX_BANK_ENABLE_N_I,
		.MAIN_BANK_ENABLE_N_I, .DUP_BANK_ENABLE_N_I, .TEST_BYPASS_I, .RESET_N_I, .PHASE_OUT_O,
		.DUP_OUT_O, .HALF_RATE_OUT_O, .DOUBLE_RATE_OUT_O, .LOCK_O);
	ref_src_model ref_src_model_i (.clk_i(CLK_I), .half_i(half_r), .fb_sel_i(fb_sel),
		.taps_i({DOUBLE_RATE_OUT_O, HALF_RATE_OUT_O, PHASE_OUT_O}), .ref_o(REFERENCE_IN_I),
		.fb_o(FEEDBACK_IN_I));

	// ==========================================================
	// checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================================
	// ahb-lite master, single words; a wait gives up after 64 cycles and stops the test
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge CLK_I);
			n++;
		end while (HREADY_I !== 1'b1 && n < 64);
		if (HREADY_I !== 1'b1) begin
			err_count++;
			stop_test();
		end
	endtask

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		HSEL_I <= 1'b1;
		HADDR_I <= a;
		HWRITE_I <= wr;
		HTRANS_I <= HTRANS_NONSEQ;
		wait_rdy();
		HSEL_I <= 1'b0;
		HTRANS_I <= 2'h0;
		HWDATA_I <= wd;
		wait_rdy();
		q = HRDATA_O;
	endtask

	// ==========================================================
	// configuration is caught only while the pin reset or the software hold bit is held
	task automatic setup(input int dv, input int cd, input int ts);
		@(posedge CLK_I);
		DIVIDER_SELECT_I <= dv[0];
		PHASE_SELECT_LSB_I <= cd[0];
		PHASE_SELECT_MSB_I <= cd[1];
		TEST_BYPASS_I <= ts[0];
		RESET_N_I <= 1'b0;
		repeat (12) @(posedge CLK_I);
		chk({PHASE_OUT_O, DUP_OUT_O, HALF_RATE_OUT_O, DOUBLE_RATE_OUT_O}, 10'h000);
		RESET_N_I <= 1'b1;
		repeat (12) @(posedge CLK_I);
		bus(1'b0, 32'(ADDR_STATUS), 32'h0);
		chk(q[4:1], {cd[1:0], dv[0], ts[0]});
		// step off the edge so callers never sample outputs as they launch
		#1;
	endtask

	function automatic logic tap(input int i, input int k, input int n, input int cd);
		int off;
		case (cd)
			0: off = 0;
			1: off = k * n / 4;
			2: off = (k == 1) ? -1 : (k == 2) ? 1 : (k == 3) ? n / 4 : 0;
			default: off = k;
		endcase
		return ((i - off + 16) % n) < n / 2;
	endfunction

	// phase a rising marks counter zero; two full periods are compared
	task automatic phases(input int n, input int cd);
		int i, k;
		logic [3:0] e;
		logic p;
		logic h;
		i = 0;
		do begin
			p = PHASE_OUT_O[0];
			@(posedge CLK_I);
			#1;
			i++;
		end while (!(PHASE_OUT_O[0] === 1'b1 && p === 1'b0) && i < 40);
		chk(i < 40, 1'b1);
		h = HALF_RATE_OUT_O;
		for (i = 0; i < 2 * n; i++) begin
			for (k = 0; k < 4; k++)
				e[k] = tap(i, k, n, cd);
			chk(PHASE_OUT_O, e);
			chk(DUP_OUT_O, e);
			chk(DOUBLE_RATE_OUT_O, (i % 4) < 2);
			chk(HALF_RATE_OUT_O, h ^ ((i / n) % 2));
			@(posedge CLK_I);
			#1;
		end
	endtask

	// reference period is ten cycles; count phase a rises over sixteen
	task automatic bypass(input int dv);
		int i, n;
		logic p;
		setup(dv, 0, 1);
		n = 0;
		for (i = 0; i < 160; i++) begin
			p = PHASE_OUT_O[0];
			@(posedge CLK_I);
			#1;
			n += (PHASE_OUT_O[0] && !p);
		end
		chk(n, dv ? 4 : 8);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (16) @(posedge CLK_I);
		RST_I <= 1'b0;
		@(posedge CLK_I);
		bus(1'b0, 32'(ADDR_CTRL), 32'h0);
		chk(q, CTRL_RST);
		bus(1'b0, 32'h0000_0040, 32'h0);
		chk(q, 32'h0);
		{AUX_BANK_ENABLE_N_I, MAIN_BANK_ENABLE_N_I, DUP_BANK_ENABLE_N_I} <= 3'h0;
		for (d = 0; d < 2; d++)
			for (c = 0; c < 4; c++) begin
				setup(d, c, 0);
				phases(d ? 8 : 4, c);
			end
		bus(1'b1, 32'(ADDR_CTRL), 32'h1);
		repeat (4) @(posedge CLK_I);
		chk({PHASE_OUT_O, DUP_OUT_O}, 8'h00);
		bus(1'b0, 32'(ADDR_CTRL), 32'h0);
		chk(q, 32'h1);
		bus(1'b1, 32'(ADDR_CTRL), 32'h0);
		half_r <= 4'h2 + 4'($random(seed) & 3);
		fb_sel <= 3'h6;
		repeat (60) @(posedge CLK_I);
		chk(LOCK_O, 1'b1);
		fb_sel <= 3'h7;
		repeat (60) @(posedge CLK_I);
		chk(LOCK_O, 1'b0);
		fb_sel <= 3'h0;
		for (d = 0; d < 24; d++) begin
			r = $random(seed);
			{AUX_BANK_ENABLE_N_I, MAIN_BANK_ENABLE_N_I, DUP_BANK_ENABLE_N_I} <= r[2:0];
			repeat (20) @(posedge CLK_I);
			if (r[1])
				chk(PHASE_OUT_O, 4'hF);
			if (r[0])
				chk(DUP_OUT_O, 4'hF);
			if (r[2])
				chk({HALF_RATE_OUT_O, DOUBLE_RATE_OUT_O}, 2'b11);
		end
		{AUX_BANK_ENABLE_N_I, MAIN_BANK_ENABLE_N_I, DUP_BANK_ENABLE_N_I} <= 3'h0;
		half_r <= 4'h5;
		bypass(0);
		bypass(1);
		stop_test();
	end

	initial begin
		repeat (100000) @(posedge CLK_I);
		err_count++;
		stop_test();
	end
endmodule
